/* File: explicit_frame_parser.sv */
// explicit-addressing transmit frame parser with apb control registers
// assumes unescaped bytes from serial api logic on mclk, one per rx_valid
// How it works
// RL1 - frame type byte 0x11 selects this decode; other types are skipped
// RL2 - nonzero frame id is echoed in a status request; zero id gives none
// RL3 - destination address offsets 5 to 12, most significant byte first
// RL4 - destination equal to broadcast value is treated as broadcast
// RL5 - host loads full unicast address of receiving node
// RL6 - host fills reserved bytes 13 and 14 with 0xFFFE
// RL7 - source endpoint offset 15, destination endpoint offset 16, both applied
// RL8 - cluster identifier at offsets 17 and 18 used for transmission
// RL9 - profile identifier at offsets 19 and 20 used for transmission
// RL10 - radius from offset 21; zero means use network max hops
// RL11 - radius above network max hops is clamped to it
// RL12 - radius ignored for unicast, applied only to broadcast
// RL13 - options offset 22; bit 0 suppresses unicast acknowledgments
// RL14 - option bit 1 skips route discovery for mesh unicast
// RL15 - option bit 2 enables negative acknowledgments for mesh packets
// RL16 - option bit 3 requests trace route for mesh packets
// RL17 - host writes zero to bits 4, 5 and undefined bits
// RL18 - bits 7:6 delivery method: 00 invalid, 01, 10, 11 mesh
// RL19 - payload from offset 23 to end, not above maximum payload
// RL20 - maximum payload count answered on a dedicated query
// RL21 - checksum is 0xFF minus low byte of sum type through payload
// RL22 - frame opens with 0x7E then big-endian 16-bit length
// RL23 - cluster and profile identifiers arrive most significant byte first
// RL24 - bad checksum or invalid delivery method frame is discarded
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module explicit_frame_parser
   import explicit_frame_pkg::*;
#(
   parameter logic [15:0] MAX_PAYLOAD = MAX_PAY_DEFAULT
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic pay_valid,
   output logic [7:0] pay_byte,
   output logic frame_done,
   output logic frame_ok,
   output logic tx_go,
   output logic [63:0] tx_dest,
   output logic tx_broadcast,
   output logic [7:0] tx_src_ep,
   output logic [7:0] tx_dst_ep,
   output logic [15:0] tx_cluster,
   output logic [15:0] tx_profile,
   output logic [7:0] tx_radius,
   output logic tx_no_ack,
   output logic tx_no_route_disc,
   output logic tx_nack_en,
   output logic tx_trace_route,
   output logic [1:0] tx_method,
   output logic stat_req,
   output logic [7:0] stat_frame_type,
   output logic [7:0] stat_frame_id,
   input wire logic max_payload_query,
   output logic max_payload_valid,
   output logic [15:0] max_payload_len
);
   parse_state_t state;
   logic [15:0] frame_len;
   logic [15:0] ofs;
   logic [7:0] sum;
   logic [7:0] ftype;
   logic [7:0] fid;
   logic [63:0] dest;
   logic [7:0] src_ep;
   logic [7:0] dst_ep;
   logic [15:0] cluster;
   logic [15:0] profile;
   logic [7:0] radius;
   logic [7:0] opts;
   logic too_long;
   logic [7:0] hops;
   logic parse_en;
   logic [15:0] good_count;
   logic [15:0] bad_count;
   logic last_body;
   logic csum_good;
   logic method_ok;
   logic is_bcast;
   logic is_mesh;
   logic accept;
   logic [7:0] next_radius;
   logic apb_wr;
   logic apb_rd;
   logic addr_hit;

   assign last_body = (ofs == frame_len + 16'h0002);
   // RL21 checksum check
   assign csum_good = ((sum + rx_byte) == CSUM_TARGET);
   // RL18 method check
   assign method_ok = (opts[OPT_METHOD_LO +: 2] != METHOD_INVALID);
   // RL4 broadcast detect
   assign is_bcast = (dest == BCAST_ADDR);
   assign is_mesh = (opts[OPT_METHOD_LO +: 2] == METHOD_MESH);
   // RL24 discard gate
   assign accept = csum_good && method_ok && !too_long && (frame_len >= MIN_LEN);

   // RL10 zero or clamped radius
   always_comb begin
      next_radius = radius;
      if (!is_bcast) begin
         // RL12 unicast ignores radius
         next_radius = 8'h00;
      end else if (radius == 8'h00 || radius > hops) begin
         // RL11 clamp to max hops
         next_radius = hops;
      end
   end

   // frame sequencing
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         frame_len <= 16'h0000;
         ofs <= 16'h0000;
         sum <= 8'h00;
      end else if (!parse_en) begin
         state <= ST_IDLE;
      end else if (rx_valid) begin
         unique case (state)
            // RL22 delimiter and length
            ST_IDLE: begin
               if (rx_byte == FRAME_DELIM) begin
                  state <= ST_LEN_HI;
               end
            end
            ST_LEN_HI: begin
               frame_len[15:8] <= rx_byte;
               state <= ST_LEN_LO;
            end
            ST_LEN_LO: begin
               frame_len[7:0] <= rx_byte;
               ofs <= OFS_TYPE;
               sum <= 8'h00;
               state <= ({frame_len[15:8], rx_byte} == 16'h0000) ? ST_IDLE : ST_BODY;
            end
            ST_BODY: begin
               sum <= sum + rx_byte;
               ofs <= ofs + 16'h0001;
               if (last_body) begin
                  state <= ST_CSUM;
               end
            end
            ST_CSUM: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // field capture
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ftype <= 8'h00;
         fid <= 8'h00;
         dest <= 64'h0000_0000_0000_0000;
         src_ep <= 8'h00;
         dst_ep <= 8'h00;
         cluster <= 16'h0000;
         profile <= 16'h0000;
         radius <= 8'h00;
         opts <= 8'h00;
         too_long <= 1'b0;
      end else if (rx_valid && state == ST_BODY) begin
         // RL1 type capture
         if (ofs == OFS_TYPE) begin
            ftype <= rx_byte;
            too_long <= 1'b0;
         end
         if (ofs == OFS_ID) begin
            fid <= rx_byte;
         end
         // RL3 address shift in
         if (ofs >= OFS_DEST_FIRST && ofs <= OFS_DEST_LAST) begin
            dest <= {dest[55:0], rx_byte};
         end
         // RL7 endpoints
         if (ofs == OFS_SRC_EP) begin
            src_ep <= rx_byte;
         end
         if (ofs == OFS_DST_EP) begin
            dst_ep <= rx_byte;
         end
         // RL23 high byte first
         if (ofs == OFS_CLUSTER_HI || ofs == OFS_CLUSTER_LO) begin
            // RL8 cluster field
            cluster <= {cluster[7:0], rx_byte};
         end
         if (ofs == OFS_PROFILE_HI || ofs == OFS_PROFILE_LO) begin
            // RL9 profile field
            profile <= {profile[7:0], rx_byte};
         end
         if (ofs == OFS_RADIUS) begin
            radius <= rx_byte;
         end
         if (ofs == OFS_OPTIONS) begin
            opts <= rx_byte;
         end
         // RL19 payload length limit
         if (ofs >= OFS_PAYLOAD && (ofs - OFS_PAYLOAD) >= MAX_PAYLOAD) begin
            too_long <= 1'b1;
         end
      end
   end

   // payload pass-through
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pay_valid <= 1'b0;
         pay_byte <= 8'h00;
      end else begin
         // RL19 payload bytes
         pay_valid <= parse_en && rx_valid && state == ST_BODY && ofs >= OFS_PAYLOAD
            && ftype == FT_EXPLICIT;
         if (rx_valid && state == ST_BODY) begin
            pay_byte <= rx_byte;
         end
      end
   end

   // frame verdict and transmit request
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frame_done <= 1'b0;
         frame_ok <= 1'b0;
         tx_go <= 1'b0;
         stat_req <= 1'b0;
         stat_frame_id <= 8'h00;
         tx_dest <= 64'h0000_0000_0000_0000;
         tx_broadcast <= 1'b0;
         tx_src_ep <= 8'h00;
         tx_dst_ep <= 8'h00;
         tx_cluster <= 16'h0000;
         tx_profile <= 16'h0000;
         tx_radius <= 8'h00;
         tx_no_ack <= 1'b0;
         tx_no_route_disc <= 1'b0;
         tx_nack_en <= 1'b0;
         tx_trace_route <= 1'b0;
         tx_method <= 2'h0;
      end else begin
         frame_done <= 1'b0;
         tx_go <= 1'b0;
         stat_req <= 1'b0;
         // RL1 only explicit frames reach here
         if (parse_en && rx_valid && state == ST_CSUM && ftype == FT_EXPLICIT) begin
            frame_done <= 1'b1;
            frame_ok <= accept;
            if (accept) begin
               tx_go <= 1'b1;
               // RL2 status only for nonzero id
               stat_req <= (fid != 8'h00);
               stat_frame_id <= fid;
               tx_dest <= dest;
               tx_broadcast <= is_bcast;
               tx_src_ep <= src_ep;
               tx_dst_ep <= dst_ep;
               tx_cluster <= cluster;
               tx_profile <= profile;
               tx_radius <= next_radius;
               // RL13 unicast ack suppress
               tx_no_ack <= opts[OPT_NO_ACK] && !is_bcast;
               // RL14 mesh unicast route skip
               tx_no_route_disc <= opts[OPT_NO_ROUTE_DISC] && !is_bcast && is_mesh;
               // RL15 mesh nack enable
               tx_nack_en <= opts[OPT_NACK] && is_mesh;
               // RL16 mesh trace route
               tx_trace_route <= opts[OPT_TRACE] && is_mesh;
               tx_method <= opts[OPT_METHOD_LO +: 2];
            end
         end
      end
   end

   assign stat_frame_type = FT_TX_STATUS;

   // RL20 maximum payload query
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         max_payload_valid <= 1'b0;
         max_payload_len <= 16'h0000;
      end else begin
         max_payload_valid <= max_payload_query;
         if (max_payload_query) begin
            max_payload_len <= MAX_PAYLOAD;
         end
      end
   end

   // apb slave, zero wait states
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;
   assign addr_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_MAX_PAY) || (paddr == ADDR_COUNTS)
      || (paddr == ADDR_DEST_HI) || (paddr == ADDR_DEST_LO) || (paddr == ADDR_APP)
      || (paddr == ADDR_OPTS);
   assign pslverr = psel && penable && !addr_hit;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hops <= HOPS_RST;
         parse_en <= 1'b1;
      end else if (apb_wr && paddr == ADDR_CTRL) begin
         hops <= pwdata[7:0];
         parse_en <= pwdata[8];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         good_count <= 16'h0000;
         bad_count <= 16'h0000;
      end else if (apb_wr && paddr == ADDR_COUNTS) begin
         // a verdict in the clear cycle is kept
         good_count <= {15'h0000, frame_done && frame_ok};
         bad_count <= {15'h0000, frame_done && !frame_ok};
      end else if (frame_done) begin
         good_count <= good_count + {15'h0000, frame_ok};
         bad_count <= bad_count + {15'h0000, !frame_ok};
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd) begin
         unique case (paddr)
            ADDR_CTRL: prdata <= {23'h00_0000, parse_en, hops};
            ADDR_MAX_PAY: prdata <= {16'h0000, MAX_PAYLOAD};
            ADDR_COUNTS: prdata <= {bad_count, good_count};
            ADDR_DEST_HI: prdata <= tx_dest[63:32];
            ADDR_DEST_LO: prdata <= tx_dest[31:0];
            ADDR_APP: prdata <= {tx_src_ep, tx_dst_ep, tx_cluster};
            ADDR_OPTS: prdata <= {tx_profile, tx_radius, tx_method, 6'h00};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   a_type_gate: assert property (@(posedge mclk) disable iff (!nrst) // RL1
      tx_go |-> ftype == FT_EXPLICIT) else $error("transmit for wrong frame type");
   a_stat_id: assert property (@(posedge mclk) disable iff (!nrst) // RL2
      stat_req |-> tx_go && stat_frame_id != 8'h00) else $error("status with zero id");
   a_bcast_detect: assert property (@(posedge mclk) disable iff (!nrst) // RL4
      tx_go |-> tx_broadcast == (tx_dest == BCAST_ADDR)) else $error("broadcast flag wrong");
   a_radius_clamp: assert property (@(posedge mclk) disable iff (!nrst) // RL11
      tx_go && tx_broadcast |-> tx_radius <= hops && (tx_radius != 8'h00 || hops == 8'h00))
      else $error("radius outside range");
   a_radius_unicast: assert property (@(posedge mclk) disable iff (!nrst) // RL12
      tx_go && !tx_broadcast |-> tx_radius == 8'h00) else $error("unicast radius used");
   a_ack_unicast: assert property (@(posedge mclk) disable iff (!nrst) // RL13
      tx_go && tx_broadcast |-> !tx_no_ack) else $error("ack suppress on broadcast");
   a_mesh_only: assert property (@(posedge mclk) disable iff (!nrst) // RL16
      tx_go && tx_method != METHOD_MESH |-> !tx_trace_route && !tx_nack_en)
      else $error("mesh option outside mesh");
   a_method_valid: assert property (@(posedge mclk) disable iff (!nrst) // RL18
      tx_go |-> tx_method != METHOD_INVALID) else $error("invalid method sent");
   a_query_answer: assert property (@(posedge mclk) disable iff (!nrst) // RL20
      max_payload_query |=> max_payload_valid && max_payload_len == MAX_PAYLOAD)
      else $error("payload query unanswered");
   a_discard_bad: assert property (@(posedge mclk) disable iff (!nrst) // RL24
      frame_done && !frame_ok |-> !tx_go && !stat_req) else $error("bad frame sent");
   a_done_follows: assert property (@(posedge mclk) disable iff (!nrst) // RL21
      state == ST_CSUM && rx_valid && parse_en && ftype == FT_EXPLICIT |=> frame_done)
      else $error("no verdict after checksum");
endmodule // explicit_frame_parser

/* File: explicit_frame_pkg.sv */
// constants for the explicit-addressing transmit frame parser
// assumes a byte stream from serial api logic on the same clock
package explicit_frame_pkg;
   localparam logic [7:0] FRAME_DELIM = 8'h7E;
   localparam logic [7:0] FT_EXPLICIT = 8'h11;
   localparam logic [7:0] FT_TX_STATUS = 8'h8B;
   localparam logic [7:0] CSUM_TARGET = 8'hFF;
   localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_FFFF;
   // frame offsets
   localparam logic [15:0] OFS_TYPE = 16'h0003;
   localparam logic [15:0] OFS_ID = 16'h0004;
   localparam logic [15:0] OFS_DEST_FIRST = 16'h0005;
   localparam logic [15:0] OFS_DEST_LAST = 16'h000C;
   localparam logic [15:0] OFS_SRC_EP = 16'h000F;
   localparam logic [15:0] OFS_DST_EP = 16'h0010;
   localparam logic [15:0] OFS_CLUSTER_HI = 16'h0011;
   localparam logic [15:0] OFS_CLUSTER_LO = 16'h0012;
   localparam logic [15:0] OFS_PROFILE_HI = 16'h0013;
   localparam logic [15:0] OFS_PROFILE_LO = 16'h0014;
   localparam logic [15:0] OFS_RADIUS = 16'h0015;
   localparam logic [15:0] OFS_OPTIONS = 16'h0016;
   localparam logic [15:0] OFS_PAYLOAD = 16'h0017;
   // length of frame type through options
   localparam logic [15:0] MIN_LEN = 16'h0014;
   // option bits
   localparam int OPT_NO_ACK = 0;
   localparam int OPT_NO_ROUTE_DISC = 1;
   localparam int OPT_NACK = 2;
   localparam int OPT_TRACE = 3;
   localparam int OPT_METHOD_LO = 6;
   localparam logic [1:0] METHOD_INVALID = 2'h0;
   localparam logic [1:0] METHOD_MESH = 2'h3;
   // apb map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MAX_PAY = 8'h04;
   localparam logic [7:0] ADDR_COUNTS = 8'h08;
   localparam logic [7:0] ADDR_DEST_HI = 8'h0C;
   localparam logic [7:0] ADDR_DEST_LO = 8'h10;
   localparam logic [7:0] ADDR_APP = 8'h14;
   localparam logic [7:0] ADDR_OPTS = 8'h18;
   localparam logic [7:0] HOPS_RST = 8'h07;
   localparam logic [15:0] MAX_PAY_DEFAULT = 16'h0100;
   typedef enum logic [2:0] {ST_IDLE, ST_LEN_HI, ST_LEN_LO, ST_BODY, ST_CSUM} parse_state_t;
endpackage

/* File: explicit_frame_host.sv */
// host controller model driving explicit transmit frames on the byte stream
// assumes the parser samples rx_byte at rising mclk while rx_valid is high
`timescale 1ns/1ps
module explicit_frame_host (
   input wire logic mclk,
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end

   // one byte, optionally after an idle cycle with a changed line
   task automatic put(input logic [7:0] b, input bit slow);
      if (slow) begin
         @(posedge mclk);
         rx_valid <= 1'b0;
         rx_byte <= ~rx_byte;
      end
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_byte <= b;
   endtask

   task automatic send(input logic [7:0] ft, input logic [7:0] fid, input logic [63:0] dest,
         input logic [47:0] app, input logic [7:0] rad, input logic [7:0] opts,
         input int npay, input bit bad, input bit slow);
      logic [7:0] body[$];
      logic [7:0] sum;
      logic [15:0] len;
      sum = 8'h00;
      body.push_back(ft);
      body.push_back(fid);
      for (int i = 7; i >= 0; i--) body.push_back(dest[i*8 +: 8]);
      body.push_back(8'hFF);
      body.push_back(8'hFE);
      for (int i = 5; i >= 0; i--) body.push_back(app[i*8 +: 8]);
      body.push_back(rad);
      body.push_back(opts);
      for (int i = 0; i < npay; i++) body.push_back(8'h30 + 8'(i));
      len = 16'(body.size());
      put(8'h7E, 1'b0);
      put(len[15:8], slow);
      put(len[7:0], slow);
      foreach (body[i]) begin
         sum = sum + body[i];
         put(body[i], slow);
      end
      put((8'hFF - sum) ^ {7'h00, bad}, slow);
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask
endmodule // explicit_frame_host

/* File: explicit_frame_parser_tb.sv */
// self-checking bench for the explicit transmit frame parser
// assumes the host model feeds bytes; apb and query are driven here
`timescale 1ns/1ps
module explicit_frame_parser_tb;
   import explicit_frame_pkg::*;
   localparam logic [15:0] MAXP = 16'h0008;
   localparam logic [63:0] UNI = 64'h0013_A200_0123_8400;
   logic mclk, nrst, psel, penable, pwrite, max_payload_query;
   logic [7:0] paddr, rx_byte, pay_byte, tx_src_ep, tx_dst_ep, tx_radius;
   logic [7:0] stat_frame_type, stat_frame_id, last_pay, got_id, got_type;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, rx_valid, pay_valid, frame_done, frame_ok, tx_go, tx_broadcast;
   logic tx_no_ack, tx_no_route_disc, tx_nack_en, tx_trace_route, stat_req, max_payload_valid;
   logic got_ok, got_go, got_stat, err;
   logic [63:0] tx_dest;
   logic [15:0] tx_cluster, tx_profile, max_payload_len;
   logic [1:0] tx_method;
   int num_errors = 0, n_tests = 0, n_pay = 0, n_done = 0, cyc = 0;
   int n_seen;

   explicit_frame_parser #(.MAX_PAYLOAD(MAXP)) u_dut (.mclk, .nrst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_byte, .pay_valid,
      .pay_byte, .frame_done, .frame_ok, .tx_go, .tx_dest, .tx_broadcast, .tx_src_ep,
      .tx_dst_ep, .tx_cluster, .tx_profile, .tx_radius, .tx_no_ack, .tx_no_route_disc,
      .tx_nack_en, .tx_trace_route, .tx_method, .stat_req, .stat_frame_type, .stat_frame_id,
      .max_payload_query, .max_payload_valid, .max_payload_len);
   explicit_frame_host u_host (.mclk, .rx_valid, .rx_byte);

   always #50 mclk = ~mclk;

   // pulse capture and watchdog
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (pay_valid === 1'b1) begin
         n_pay <= n_pay + 1;
         last_pay <= pay_byte;
      end
      if (frame_done === 1'b1) begin
         n_done <= n_done + 1;
         got_ok <= frame_ok;
         got_go <= tx_go;
         got_stat <= stat_req;
         got_id <= stat_frame_id;
         got_type <= stat_frame_type;
      end
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      forever begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_regs;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'h0000_0107, rd);
      apb(1'b1, ADDR_CTRL, 32'h0000_0105);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h0000_0105, rd);
      apb(1'b1, ADDR_MAX_PAY, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_MAX_PAY, 32'h0);
      chk("max pay reg", {16'h0000, MAXP}, rd);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 33'h1_0000_0000, {err, rd});
      @(posedge mclk);
      max_payload_query <= 1'b1;
      @(posedge mclk);
      max_payload_query <= 1'b0;
      #1;
      chk("query", {1'b1, MAXP}, {max_payload_valid, max_payload_len});
      @(posedge mclk);
      #1;
      chk("query pulse", 1'b0, max_payload_valid);
   endtask

   task automatic run_case(input logic [7:0] ft, input logic [7:0] fid, input logic [63:0] dest,
         input logic [7:0] rad, input logic [7:0] opts, input int npay, input bit bad,
         input bit slow, input bit ok);
      logic [47:0] app;
      logic bc, mesh;
      int d0, p0;
      app = {8'hE8, fid, 16'h0011 + 16'(fid), 16'hC105 ^ {fid, fid}};
      bc = (dest === BCAST_ADDR);
      mesh = (opts[7:6] === METHOD_MESH);
      d0 = n_done;
      p0 = n_pay;
      u_host.send(ft, fid, dest, app, rad, opts, npay, bad, slow);
      repeat (3) @(posedge mclk);
      #1;
      chk("pay count", p0 + ((ft === FT_EXPLICIT) ? npay : 0), n_pay);
      if (ft !== FT_EXPLICIT) begin
         chk("foreign type", d0, n_done);
         return;
      end
      if (npay > 0) chk("last pay", 8'h30 + 8'(npay - 1), last_pay);
      chk("done", d0 + 1, n_done);
      chk("ok", ok, got_ok);
      chk("go", ok, got_go);
      chk("stat", ok && fid != 0, got_stat);
      if (!ok) return;
      if (fid != 0) chk("stat id", {FT_TX_STATUS, fid}, {got_type, got_id});
      chk("dest", dest, tx_dest);
      chk("bcast", bc, tx_broadcast);
      chk("endpoints", app[47:32], {tx_src_ep, tx_dst_ep});
      chk("cluster", app[31:16], tx_cluster);
      chk("profile", app[15:0], tx_profile);
      chk("radius", bc ? ((rad == 0 || rad > 5) ? 8'd5 : rad) : 8'd0, tx_radius);
      chk("no ack", opts[0] & ~bc, tx_no_ack);
      chk("no route", opts[1] & ~bc & mesh, tx_no_route_disc);
      chk("nack", opts[2] & mesh, tx_nack_en);
      chk("trace", opts[3] & mesh, tx_trace_route);
      chk("method", opts[7:6], tx_method);
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      max_payload_query = 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      run_case(8'h11, 8'h01, UNI, 8'h05, 8'hC3, 6, 0, 0, 1);
      run_case(8'h11, 8'h00, BCAST_ADDR, 8'h00, 8'h4C, 8, 0, 1, 1);
      run_case(8'h11, 8'h7F, BCAST_ADDR, 8'h09, 8'h8F, 0, 0, 0, 1);
      run_case(8'h11, 8'h22, BCAST_ADDR, 8'h03, 8'hCE, 1, 0, 0, 1);
      run_case(8'h11, 8'h05, UNI, 8'h00, 8'h01, 2, 0, 0, 0);
      run_case(8'h11, 8'h06, UNI, 8'h00, 8'h40, 2, 1, 0, 0);
      run_case(8'h11, 8'h07, UNI, 8'h00, 8'h40, 9, 0, 0, 0);
      run_case(8'h10, 8'h08, UNI, 8'h00, 8'h40, 2, 0, 0, 0);
      run_case(8'h11, 8'h09, UNI, 8'h00, 8'hCA, 3, 0, 1, 1);
      apb(1'b0, ADDR_COUNTS, 32'h0);
      chk("counts", 32'h0003_0005, rd);
      apb(1'b0, ADDR_DEST_HI, 32'h0);
      chk("dest hi reg", UNI[63:32], rd);
      apb(1'b0, ADDR_DEST_LO, 32'h0);
      chk("dest lo reg", UNI[31:0], rd);
      apb(1'b0, ADDR_APP, 32'h0);
      chk("app reg", 32'hE809_001A, rd);
      apb(1'b0, ADDR_OPTS, 32'h0);
      chk("opts reg", 32'hC80C_00C0, rd);
      apb(1'b1, ADDR_COUNTS, 32'h0);
      apb(1'b0, ADDR_COUNTS, 32'h0);
      chk("counts clear", 32'h0, rd);
      apb(1'b1, ADDR_CTRL, 32'h0000_0005);
      n_seen = n_done + n_pay;
      u_host.send(8'h11, 8'h0A, UNI, 48'h0000_0000_0000, 8'h00, 8'h40, 1, 0, 0);
      repeat (3) @(posedge mclk);
      #1;
      chk("parse off", n_seen, n_done + n_pay);
      wrap_up();
   end
endmodule // explicit_frame_parser_tb
